/* File: inc/sglk_defines.svh */
`ifndef SGLK_DEFINES_SVH
`define SGLK_DEFINES_SVH

// ----------------------------------------------------------------
// timing figures in their own units
// ----------------------------------------------------------------
`define SGLK_CLOCK_HZ 10000000
`define SGLK_LOCK_TIMEOUT_MS 600
`define SGLK_REARM_LOW_MS 500

// derived cycle counts; 600 ms and 500 ms are whole cycles at 10 MHz
`define SGLK_LOCK_TIMEOUT_CYCLES (`SGLK_LOCK_TIMEOUT_MS * (`SGLK_CLOCK_HZ / 1000))
`define SGLK_REARM_LOW_CYCLES (`SGLK_REARM_LOW_MS * (`SGLK_CLOCK_HZ / 1000))

// ----------------------------------------------------------------
// holding force test
// ----------------------------------------------------------------
`define SGLK_EXTRA_TESTS 7

// ----------------------------------------------------------------
// synchronised input vector layout
// ----------------------------------------------------------------
`define SGLK_IN_WIDTH 5

`endif

/* File: inc/sglk_pkg.sv */
package sglk_pkg;

  // ----------------------------------------------------------------
  // inputs after the synchroniser, one bit each
  // ----------------------------------------------------------------
  typedef struct packed {
    logic actuator;
    logic safety_input_a;
    logic safety_input_b;
    logic lock_request;
    logic holding_force;
  } sglk_inputs_t;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SGLK_PL_NORMAL,
    SGLK_PL_UNEQUAL,
    SGLK_PL_PART_LOCK
  } sglk_plaus_t;

  typedef enum logic [1:0] {
    SGLK_LK_IDLE,
    SGLK_LK_TESTING,
    SGLK_LK_LOCKED,
    SGLK_LK_FAILED
  } sglk_lock_t;

endpackage : sglk_pkg

/* File: logic/sglk_sync.sv */
// ----------------------------------------------------------------
// two flip-flop synchroniser, one per bit
// ----------------------------------------------------------------
module sglk_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // asynchronous levels
  input wire logic [WIDTH-1:0] i_async,
  // synchronised levels
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // first stage is read only by the second stage
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : sglk_sync

/* File: logic/sglk_gate.sv */
`include "sglk_defines.svh"
module sglk_gate
  import sglk_pkg::*;
#(
  parameter int unsigned LOCK_TIMEOUT_CYCLES = `SGLK_LOCK_TIMEOUT_CYCLES,
  parameter int unsigned REARM_LOW_CYCLES = `SGLK_REARM_LOW_CYCLES,
  parameter int unsigned EXTRA_TESTS = `SGLK_EXTRA_TESTS
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // field inputs, asynchronous
  input wire logic i_actuator_present,
  input wire logic i_safety_input_a,
  input wire logic i_safety_input_b,
  input wire logic i_lock_request,
  input wire logic i_holding_force,
  // safety outputs
  output logic o_safety_output_a,
  output logic o_safety_output_b,
  // signal output and magnet drive
  output logic o_gate_status_output,
  output logic o_lock_magnet,
  // indications
  output logic o_lock_fault,
  output logic o_lock_active,
  output logic o_unequal_state,
  output logic o_plausibility_error,
  output logic o_inputs_high
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] sglk_sat_inc(input logic [31:0] value,
                                               input logic [31:0] limit);
    if (value >= limit) begin
      return limit;
    end
    return value + 32'h0000_0001;
  endfunction : sglk_sat_inc

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  sglk_inputs_t in_sync;
  logic [`SGLK_IN_WIDTH-1:0] in_raw;
  logic [`SGLK_IN_WIDTH-1:0] in_vec;

  assign in_raw = {i_actuator_present, i_safety_input_a, i_safety_input_b,
                   i_lock_request, i_holding_force};

  // every decision below looks only at the synchronised copy
  sglk_sync #(
    .WIDTH(`SGLK_IN_WIDTH)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async(in_raw),
    .o_sync(in_vec)
  );

  assign in_sync = sglk_inputs_t'(in_vec);

  // ----------------------------------------------------------------
  // plausibility monitoring of the two safety inputs
  // ----------------------------------------------------------------
  sglk_plaus_t plaus;
  logic prev_a;
  logic prev_b;

  // previous sample, to see which input fell
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      prev_a <= in_sync.safety_input_a;
      prev_b <= in_sync.safety_input_b;
    end
  end

  // a falls-and-rises on one channel alone looks like a bridged or stuck pair
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      plaus <= SGLK_PL_NORMAL;
    end else begin
      case (plaus)
        SGLK_PL_NORMAL: begin
          if (prev_a && prev_b && (in_sync.safety_input_a != in_sync.safety_input_b)) begin
            plaus <= SGLK_PL_UNEQUAL;
          end
        end
        SGLK_PL_UNEQUAL: begin
          if (!in_sync.safety_input_a && !in_sync.safety_input_b) begin
            plaus <= SGLK_PL_NORMAL;
          end else if (in_sync.safety_input_a && in_sync.safety_input_b) begin
            plaus <= SGLK_PL_PART_LOCK;
          end
        end
        SGLK_PL_PART_LOCK: begin
          if (!in_sync.safety_input_a && !in_sync.safety_input_b) begin
            plaus <= SGLK_PL_NORMAL;
          end
        end
        default: begin
          plaus <= SGLK_PL_PART_LOCK;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // lock request low time, for the re-arm after a fault
  // ----------------------------------------------------------------
  logic [31:0] low_count;
  logic low_done;

  assign low_done = (low_count >= REARM_LOW_CYCLES);

  // saturates; cleared the cycle the request is seen high
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_count <= 32'h0000_0000;
    end else if (in_sync.lock_request) begin
      low_count <= 32'h0000_0000;
    end else begin
      low_count <= sglk_sat_inc(low_count, REARM_LOW_CYCLES);
    end
  end

  // ----------------------------------------------------------------
  // guard locking and holding force test
  // ----------------------------------------------------------------
  sglk_lock_t lock_state;
  logic [31:0] test_count;
  logic [31:0] retry_count;
  logic powerup_test;
  logic test_expired;

  assign test_expired = (test_count >= LOCK_TIMEOUT_CYCLES - 1);

  // test timer runs only while a holding test is under way
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      test_count <= 32'h0000_0000;
    end else if (lock_state != SGLK_LK_TESTING || test_expired) begin
      test_count <= 32'h0000_0000;
    end else begin
      test_count <= sglk_sat_inc(test_count, LOCK_TIMEOUT_CYCLES);
    end
  end

  // power-up flag: the first holding test after reset is retried quietly
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      powerup_test <= 1'b1;
    end else if (lock_state == SGLK_LK_LOCKED || lock_state == SGLK_LK_FAILED) begin
      powerup_test <= 1'b0;
    end
  end

  // lock sequencing; the timeout has no grace, a magnet that is late is a fault, except in the power-up test, which first retries up to EXTRA_TESTS times
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_state <= SGLK_LK_IDLE;
      retry_count <= 32'h0000_0000;
    end else begin
      case (lock_state)
        SGLK_LK_IDLE: begin
          retry_count <= 32'h0000_0000;
          if (in_sync.lock_request && in_sync.actuator) begin
            lock_state <= SGLK_LK_TESTING;
          end
        end
        SGLK_LK_TESTING: begin
          if (!in_sync.lock_request) begin
            lock_state <= SGLK_LK_IDLE;
          end else if (!in_sync.actuator) begin
            lock_state <= SGLK_LK_FAILED;
          end else if (in_sync.holding_force) begin
            lock_state <= SGLK_LK_LOCKED;
          end else if (test_expired) begin
            if (powerup_test && retry_count < EXTRA_TESTS) begin
              retry_count <= retry_count + 32'h0000_0001;
            end else begin
              lock_state <= SGLK_LK_FAILED;
            end
          end
        end
        SGLK_LK_LOCKED: begin
          if (!in_sync.actuator) begin
            lock_state <= SGLK_LK_FAILED;
          end else if (!in_sync.lock_request) begin
            lock_state <= SGLK_LK_IDLE;
          end
        end
        SGLK_LK_FAILED: begin
          // request must have stood low long enough before this rise
          if (in_sync.lock_request && low_done) begin
            lock_state <= in_sync.actuator ? SGLK_LK_TESTING : SGLK_LK_IDLE;
          end
        end
        default: begin
          lock_state <= SGLK_LK_FAILED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next values of the outputs
  // ----------------------------------------------------------------
  logic next_safety;
  logic next_gate_status;
  logic next_magnet;
  logic status_blocked;

  // the power-up test holds status low until it passes
  assign status_blocked = (lock_state == SGLK_LK_FAILED) || (powerup_test &&
                          lock_state != SGLK_LK_LOCKED && in_sync.lock_request);

  // no lock term here: safety outputs do not care about guard locking
  assign next_safety = in_sync.actuator && in_sync.safety_input_a &&
                       in_sync.safety_input_b && (plaus != SGLK_PL_PART_LOCK);

  assign next_gate_status = in_sync.actuator && !status_blocked;

  assign next_magnet = in_sync.lock_request && in_sync.actuator &&
                       (lock_state == SGLK_LK_TESTING || lock_state == SGLK_LK_LOCKED);

  // ----------------------------------------------------------------
  // output flip-flops
  // ----------------------------------------------------------------
  // actuator loss, forced or not, drops both channels together
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_safety_output_a <= 1'b0;
      o_safety_output_b <= 1'b0;
    end else begin
      o_safety_output_a <= next_safety;
      o_safety_output_b <= next_safety;
    end
  end

  // gate status follows the actuator unless a lock fault or the power-up test holds it down
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_gate_status_output <= 1'b0;
    end else begin
      o_gate_status_output <= next_gate_status;
    end
  end

  // magnet drive
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lock_magnet <= 1'b0;
    end else begin
      o_lock_magnet <= next_magnet;
    end
  end

  // indications
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lock_fault <= 1'b0;
      o_lock_active <= 1'b0;
      o_unequal_state <= 1'b0;
      o_plausibility_error <= 1'b0;
      o_inputs_high <= 1'b0;
    end else begin
      o_lock_fault <= (lock_state == SGLK_LK_FAILED);
      o_lock_active <= (lock_state == SGLK_LK_LOCKED) && next_gate_status;
      o_unequal_state <= (plaus == SGLK_PL_UNEQUAL);
      o_plausibility_error <= (plaus == SGLK_PL_PART_LOCK);
      o_inputs_high <= in_sync.safety_input_a && in_sync.safety_input_b;
    end
  end

endmodule : sglk_gate

/* File: bench/sglk_assertions.sv */
// ----------------------------------------------------------------
// port checker for the gate lock block
// ----------------------------------------------------------------
module sglk_checker (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // field inputs
  input wire logic i_actuator_present,
  input wire logic i_safety_input_a,
  input wire logic i_safety_input_b,
  input wire logic i_lock_request,
  // outputs under watch
  input wire logic o_safety_output_a,
  input wire logic o_gate_status_output,
  input wire logic o_lock_magnet,
  input wire logic o_lock_fault,
  input wire logic o_lock_active,
  input wire logic o_unequal_state,
  input wire logic o_plausibility_error
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] req_h;
  logic [4:0] act_h;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  // history of inputs; magnet latency may be 3 to 5 edges
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_h <= 5'h00;
      act_h <= 5'h00;
    end else begin
      req_h <= {req_h[3:0], i_lock_request};
      act_h <= {act_h[3:0], i_actuator_present};
    end
  end

  // a level needs three edges to cross the sync and output flops
  sequence s_a_drop;
    $fell(i_safety_input_a) && i_safety_input_b && $past(i_safety_input_b)
      ##1 (!i_safety_input_a && i_safety_input_b) [*3];
  endsequence
  sequence s_closed;
    (i_actuator_present && !i_lock_request && !o_lock_fault) [*4];
  endsequence

  property p_out_cause;
    o_safety_output_a |-> $past(i_actuator_present, 3) && $past(i_safety_input_a, 3)
      && $past(i_safety_input_b, 3);
  endproperty
  property p_forced;
    $fell(i_actuator_present) && o_lock_active |-> ##3 !o_safety_output_a;
  endproperty
  property p_open;
    !$past(i_actuator_present, 3) |-> !o_gate_status_output;
  endproperty
  property p_closed;
    s_closed |-> o_gate_status_output;
  endproperty
  property p_fault_gate;
    o_lock_fault |-> !o_gate_status_output;
  endproperty
  property p_unequal;
    s_a_drop |-> ##[0:2] o_unequal_state;
  endproperty
  property p_plaus;
    o_plausibility_error && $past(o_plausibility_error) |-> !o_safety_output_a;
  endproperty
  property p_active;
    o_lock_active |-> o_gate_status_output;
  endproperty
  property p_magnet;
    o_lock_magnet |-> (|req_h[4:2]) && (|act_h[4:2]);
  endproperty

  a_out_cause: assert property (p_out_cause)
    else $error("safety output on without cause");
  a_forced: assert property (p_forced)
    else $error("safety output on after forced opening");
  a_open: assert property (p_open)
    else $error("gate status high with actuator away");
  a_closed: assert property (p_closed)
    else $error("gate status low with gate closed and no request");
  a_fault_gate: assert property (p_fault_gate)
    else $error("gate status high during lock fault");
  a_unequal: assert property (p_unequal)
    else $error("unequal state not flagged");
  a_plaus: assert property (p_plaus)
    else $error("safety output on in partial operation lock");
  a_active: assert property (p_active)
    else $error("lock active without gate status");
  a_magnet: assert property (p_magnet)
    else $error("magnet on without request and actuator");
endmodule : sglk_checker

/* File: bench/sglk_partner.sv */
// ----------------------------------------------------------------
// evaluation device: issues the lock request, watches both channels
// ----------------------------------------------------------------
module sglk_partner #(
  parameter int unsigned REARM_LOW_CYCLES = 15
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // commands from the bench
  input wire logic i_cmd_request,
  input wire logic i_rude,
  // channels under evaluation
  input wire logic i_safety_output_a,
  input wire logic i_safety_output_b,
  // request line and verdict
  output logic o_lock_request,
  output logic o_pair_err
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned low_cnt;

  // request rises only after a long enough low time, unless told to be rude
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_cnt <= 0;
      o_lock_request <= 1'b0;
    end else begin
      low_cnt <= o_lock_request ? 0 : low_cnt + 1;
      // two spare cycles cover the device's synchroniser
      o_lock_request <= i_cmd_request && (o_lock_request || i_rude
        || low_cnt >= REARM_LOW_CYCLES + 2);
    end
  end

  // two-channel plausibility: both outputs must always agree
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pair_err <= 1'b0;
    end else begin
      o_pair_err <= o_pair_err || (i_safety_output_a !== i_safety_output_b);
    end
  end
endmodule : sglk_partner

/* File: bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // bench signals; short counts keep the run small
  // ----------------------------------------------------------------
  localparam int unsigned TO = 20;
  localparam int unsigned RA = 15;
  localparam int OA = 0, GT = 2, MG = 3, FT = 4, AC = 5, UQ = 6, PL = 7;
  logic i_clock, i_rst_b, act, sa, sb, hold, cmd, rude;
  wire logic req, oa, ob, gate, mag, fault, active, uneq, plaus, inhi, pair_err;
  wire logic [7:0] ov = {plaus, uneq, active, fault, mag, gate, ob, oa};
  int bad_count, cmp_count;

  sglk_gate #(.LOCK_TIMEOUT_CYCLES(TO), .REARM_LOW_CYCLES(RA), .EXTRA_TESTS(7)) sglk_gate_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_actuator_present(act), .i_safety_input_a(sa),
    .i_safety_input_b(sb), .i_lock_request(req), .i_holding_force(hold),
    .o_safety_output_a(oa), .o_safety_output_b(ob), .o_gate_status_output(gate),
    .o_lock_magnet(mag), .o_lock_fault(fault), .o_lock_active(active),
    .o_unequal_state(uneq), .o_plausibility_error(plaus), .o_inputs_high(inhi));
  sglk_partner #(.REARM_LOW_CYCLES(RA)) sglk_partner_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_cmd_request(cmd), .i_rude(rude),
    .i_safety_output_a(oa), .i_safety_output_b(ob), .o_lock_request(req),
    .o_pair_err(pair_err));

  // clock and watchdog
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    $display("FAIL watchdog expected end seen hang");
    end_sim();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input string name, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk
  // inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : step
  task automatic drive(input logic a0, input logic a1, input logic a2, input logic a3);
    step(1);
    act = a0;
    sa = a1;
    sb = a2;
    hold = a3;
  endtask : drive
  task automatic ask(input logic v, input logic r);
    step(1);
    cmd = v;
    rude = r;
  endtask : ask
  // bounded wait; a miss ends the run since later steps rely on it
  task automatic wait_for(input string name, input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (ov[idx] !== val && n < lim) begin
      step(1);
      n++;
    end
    chk(name, ov[idx], val);
    if (ov[idx] !== val) end_sim();
  endtask : wait_for
  task automatic keep(input string name, input int idx, input logic val, input int n);
    repeat (n) begin
      step(1);
      chk(name, ov[idx], val);
    end
  endtask : keep

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_safety();
    chk("outputs after reset", |ov, 1'b0);
    drive(1, 1, 1, 0);
    wait_for("outputs on", OA, 1, 6);
    chk("channel b", ob, 1'b1);
    chk("inputs high", inhi, 1'b1);
    wait_for("gate closed", GT, 1, 3);
    drive(1, 0, 0, 0);
    wait_for("outputs off inputs low", OA, 0, 6);
    drive(1, 1, 1, 0);
    wait_for("outputs back on", OA, 1, 6);
    drive(0, 1, 1, 0);
    wait_for("outputs off gate open", OA, 0, 6);
    wait_for("gate open", GT, 0, 2);
    $display("safety test done");
  endtask : t_safety
  // request waits for the actuator, so its arrival starts the power-up test
  task automatic t_powerup();
    ask(1, 0);
    step(25);
    drive(1, 1, 1, 0);
    keep("gate before test", GT, 0, 4);
    wait_for("magnet on", MG, 1, 8);
    keep("gate during power-up test", GT, 0, 5 * TO);
    chk("no fault in retries", fault, 1'b0);
    chk("outputs during test", oa, 1'b1);
    drive(1, 1, 1, 1);
    wait_for("locked on retry", AC, 1, 10);
    chk("gate after lock", gate, 1'b1);
    $display("power-up test done");
  endtask : t_powerup
  task automatic t_timeout();
    ask(0, 0);
    drive(1, 1, 1, 0);
    keep("gate request low", GT, 1, 20);
    chk("magnet released", mag, 1'b0);
    ask(1, 0);
    wait_for("magnet again", MG, 1, 30);
    keep("gate within window", GT, 1, 12);
    wait_for("gate after timeout", GT, 0, 20);
    chk("fault after timeout", fault, 1'b1);
    ask(0, 0);
    step(5);
    ask(1, 1);
    keep("gate after early rise", GT, 0, 20);
    chk("fault kept", fault, 1'b1);
    ask(0, 0);
    step(RA + 6);
    ask(1, 0);
    wait_for("gate rearmed", GT, 1, 8);
    chk("fault cleared", fault, 1'b0);
    drive(1, 1, 1, 1);
    wait_for("locked again", AC, 1, 10);
    $display("timeout test done");
  endtask : t_timeout
  task automatic t_forced();
    drive(0, 1, 1, 1);
    wait_for("outputs off forced", OA, 0, 5);
    wait_for("gate off forced", GT, 0, 2);
    wait_for("fault forced", FT, 1, 3);
    wait_for("lock active off", AC, 0, 3);
    ask(0, 0);
    $display("forced test done");
  endtask : t_forced
  task automatic t_plaus();
    drive(1, 1, 1, 0);
    wait_for("outputs with lock fault", OA, 1, 6);
    drive(1, 0, 1, 0);
    wait_for("unequal flagged", UQ, 1, 8);
    wait_for("outputs off one low", OA, 0, 4);
    drive(1, 1, 1, 0);
    wait_for("plausibility error", PL, 1, 8);
    keep("outputs in part lock", OA, 0, 10);
    drive(1, 0, 0, 0);
    step(4);
    drive(1, 1, 1, 0);
    wait_for("outputs resumed", OA, 1, 8);
    chk("part lock left", plaus, 1'b0);
    $display("plausibility test done");
  endtask : t_plaus

  // main sequence
  initial begin
    i_rst_b = 1'b0;
    act = 1'b0;
    sa = 1'b0;
    sb = 1'b0;
    hold = 1'b0;
    cmd = 1'b0;
    rude = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge i_clock);
    #1 i_rst_b = 1'b1;
    step(1);
    t_safety();
    t_powerup();
    t_timeout();
    t_forced();
    t_plaus();
    chk("channel pair", pair_err, 1'b0);
    end_sim();
  end
endmodule : tb_top

bind sglk_gate sglk_checker sglk_checker_i (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_actuator_present(i_actuator_present),
  .i_safety_input_a(i_safety_input_a), .i_safety_input_b(i_safety_input_b),
  .i_lock_request(i_lock_request), .o_safety_output_a(o_safety_output_a),
  .o_gate_status_output(o_gate_status_output), .o_lock_magnet(o_lock_magnet),
  .o_lock_fault(o_lock_fault), .o_lock_active(o_lock_active),
  .o_unequal_state(o_unequal_state), .o_plausibility_error(o_plausibility_error));
